// File: design/lpsm_pkg.sv
// Shared constants, commands and states of the power and bank state machine
package lpsm_pkg;
    typedef enum logic [3:0] {
        CMD_NOP, CMD_MRW, CMD_MRR, CMD_REFPB, CMD_REFAB, CMD_ACT, CMD_WR, CMD_RD,
        CMD_PRE, CMD_BST, CMD_RESET, CMD_SREF, CMD_DPD
    } lpsm_cmd_t;
    typedef enum logic [4:0] {
        ST_POWERON, ST_RESETTING, ST_IDLE, ST_ACTIVATING, ST_ACTIVE, ST_READING, ST_WRITING,
        ST_PRECHARGING, ST_REFPB, ST_REFAB, ST_MRWRITING, ST_IDLE_MRR, ST_ACT_MRR, ST_RST_MRR,
        ST_ACT_PD, ST_IDLE_PD, ST_RST_PD, ST_SELFREF, ST_DEEP_PD
    } lpsm_state_t;
    localparam int CLK_MHZ = 100;
    // Timing figures in ns
    localparam int T_RP_NS = 18;
    localparam int T_RCD_NS = 18;
    localparam int T_RFCPB_NS = 90;
    localparam int T_RFCAB_NS = 130;
    localparam int T_MRR_NS = 20;
    localparam int T_MRW_NS = 50;
    localparam int T_XP_NS = 8;
    localparam int T_XSR_NS = 140;
    localparam int T_INIT5_NS = 10000;
    // Minimum times round up, at least one cycle
    function automatic int lpsm_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : lpsm_cyc
    localparam int TIMER_W = 16;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 16'h0001;
    localparam logic [3:0] LINK_DIV = 4'h4;
    localparam logic [7:0] HOLD_NOP_CYC = 8'h20;
endpackage : lpsm_pkg

// File: design/lpsm_link_if.sv
// Command link between memory controller and device state machine
`timescale 1ns/1ps
interface lpsm_link_if;
    import lpsm_pkg::*;
    logic linkClk;
    logic cke;
    logic csN;
    lpsm_cmd_t cmd;
    logic allBanks;
    logic autoPre;
    logic [7:0] modeAddr;
    logic [7:0] modeData;
    logic [7:0] readData;
    logic readValid;
    modport ctrl (output linkClk, output cke, output csN, output cmd, output allBanks, output autoPre,
        output modeAddr, output modeData, input readData, input readValid);
    modport dev (input linkClk, input cke, input csN, input cmd, input allBanks, input autoPre,
        input modeAddr, input modeData, output readData, output readValid);
endinterface : lpsm_link_if

// File: design/lpsm_device.sv
// Device end: clock-enable power states and same-bank command state machine
// What this block does
// (R1) Next state from prior state, CKE history, command
// (R2) Sample CKE each edge, compare with previous
// (R3) Unlisted combinations are illegal; device ignores them
// (R4) CKE low twice holds low-power state
// (R5) CKE falling enters power state by state
// (R6) CKE high both edges follows command table
// (R7) Controller waits exit time after power-down exit
// (R8) Controller toggles clock twice before exit wait
// (R9) Resetting power-down exit: idle if init expired
// (R10) Deep power-down exit goes to power-on
// (R11) Commands honoured only after exit time met
// (R12) Idle: activate opens row, refresh refreshes
// (R13) Idle mode write; reset starts initialization
// (R14) Mode read enters matching MR reading state
// (R15) Precharge from idle or active enters precharging
// (R16) Read restarts read; write switches to writing
// (R17) Write restarts write; read switches to reading
// (R18) Burst-terminate returns reading or writing to active
// (R19) Idle after row-precharge time; NOP holds state
// (R20) Active after activate-to-column delay, no access
// (R21) Controller sends nothing to busy bank
// (R22) Precharging and activating end after their times
// (R23) Controller sends NOPs during refresh and MR access
// (R24) Precharge of idle bank still waits row-precharge
`timescale 1ns/1ps
module lpsm_device
    import lpsm_pkg::*;
#(
    parameter int INIT5_CYC = lpsm_cyc(T_INIT5_NS)
)(
    input wire logic sys_clk,
    input wire logic rst_n,
    lpsm_link_if.dev link,
    output lpsm_state_t state,
    output logic illegal,
    output logic exitWait
);
    initial
    begin
        if (INIT5_CYC < 1 || INIT5_CYC > 65535)
            $error("INIT5_CYC out of range");
    end

    logic [2:0] clkSync;
    logic ckeS1, ckeS2, csS1, csS2;
    lpsm_cmd_t cmdS1, cmdS2;
    logic allS1, allS2;
    logic [7:0] maS1, maS2, mdS1, mdS2;
    logic ckePrev;
    logic edgeN;
    lpsm_state_t next_state;
    logic [TIMER_W-1:0] timer, next_timer;
    logic [TIMER_W-1:0] initTimer;
    logic [TIMER_W-1:0] exitTimer, next_exitTimer;
    logic [7:0] modeRegs [0:255];
    logic cmdOk;

    // Two-stage sync of link clock and pins, then rising-edge detect
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clkSync <= 3'h0;
            ckeS1 <= 1'b1;
            ckeS2 <= 1'b1;
            csS1 <= 1'b1;
            csS2 <= 1'b1;
            cmdS1 <= CMD_NOP;
            cmdS2 <= CMD_NOP;
            allS1 <= 1'b0;
            allS2 <= 1'b0;
            maS1 <= 8'h00;
            maS2 <= 8'h00;
            mdS1 <= 8'h00;
            mdS2 <= 8'h00;
        end
        else
        begin
            clkSync <= {clkSync[1:0], link.linkClk};
            ckeS1 <= link.cke;
            ckeS2 <= ckeS1;
            csS1 <= link.csN;
            csS2 <= csS1;
            cmdS1 <= link.cmd;
            cmdS2 <= cmdS1;
            allS1 <= link.allBanks;
            allS2 <= allS1;
            maS1 <= link.modeAddr;
            maS2 <= maS1;
            mdS1 <= link.modeData;
            mdS2 <= mdS1;
        end
    end
    assign edgeN = clkSync[1] & ~clkSync[2];

    // Previous-edge CKE [R2]
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ckePrev <= 1'b1;
        else if (edgeN)
            ckePrev <= ckeS2; // [R2]
    end

    // Commands are acted on only with chip select low and exit time met
    assign cmdOk = !csS2 && exitTimer == TIMER_ZERO; // [R11]
    assign exitWait = exitTimer != TIMER_ZERO;

    always_comb
    begin
        next_state = state;
        next_timer = (timer != TIMER_ZERO) ? timer - TIMER_ONE : TIMER_ZERO;
        next_exitTimer = (exitTimer != TIMER_ZERO) ? exitTimer - TIMER_ONE : TIMER_ZERO;
        // Timed states end when their count expires [R22]
        if (timer == TIMER_ONE)
        begin
            case (state)
                ST_ACTIVATING: next_state = ST_ACTIVE; // [R20] [R22]
                ST_PRECHARGING, ST_REFPB, ST_REFAB, ST_MRWRITING, ST_IDLE_MRR, ST_RST_MRR:
                    next_state = ST_IDLE; // [R19] [R22]
                ST_ACT_MRR: next_state = ST_ACTIVE;
                default: next_state = state;
            endcase
        end
        if (edgeN)
        begin
            if (!ckePrev && !ckeS2)
                next_state = state; // [R4]
            else if (!ckePrev && ckeS2)
            begin
                if (csS2) // [R4]
                begin
                    case (state)
                        ST_ACT_PD:
                        begin
                            next_state = ST_ACTIVE;
                            next_exitTimer = TIMER_W'(lpsm_cyc(T_XP_NS));
                        end
                        ST_IDLE_PD:
                        begin
                            next_state = ST_IDLE;
                            next_exitTimer = TIMER_W'(lpsm_cyc(T_XP_NS));
                        end
                        ST_RST_PD:
                        begin
                            next_state = (initTimer == TIMER_ZERO) ? ST_IDLE : ST_RESETTING; // [R9]
                            next_exitTimer = TIMER_W'(lpsm_cyc(T_XP_NS));
                        end
                        ST_SELFREF:
                        begin
                            next_state = ST_IDLE;
                            next_exitTimer = TIMER_W'(lpsm_cyc(T_XSR_NS));
                        end
                        ST_DEEP_PD: next_state = ST_POWERON; // [R10]
                        default: next_state = state;
                    endcase
                end
            end
            else if (ckePrev && !ckeS2)
            begin
                // Power state chosen by current state [R5]
                case (state)
                    ST_ACTIVE: if (csS2) next_state = ST_ACT_PD; // [R5]
                    ST_IDLE:
                    begin
                        if (csS2 || cmdS2 == CMD_NOP)
                            next_state = ST_IDLE_PD; // [R5]
                        else if (cmdS2 == CMD_SREF)
                            next_state = ST_SELFREF; // [R5]
                        else if (cmdS2 == CMD_DPD)
                            next_state = ST_DEEP_PD; // [R5]
                    end
                    ST_RESETTING: if (csS2) next_state = ST_RST_PD; // [R5]
                    default: next_state = state;
                endcase
            end
            else if (cmdOk) // [R6] [R1]
            begin
                case (state)
                    ST_IDLE:
                    begin
                        case (cmdS2)
                            CMD_ACT:
                            begin
                                next_state = ST_ACTIVATING; // [R12]
                                next_timer = TIMER_W'(lpsm_cyc(T_RCD_NS));
                            end
                            CMD_REFPB:
                            begin
                                next_state = ST_REFPB; // [R12]
                                next_timer = TIMER_W'(lpsm_cyc(T_RFCPB_NS));
                            end
                            CMD_REFAB:
                            begin
                                next_state = ST_REFAB; // [R12]
                                next_timer = TIMER_W'(lpsm_cyc(T_RFCAB_NS));
                            end
                            CMD_MRW:
                            begin
                                next_state = ST_MRWRITING; // [R13]
                                next_timer = TIMER_W'(lpsm_cyc(T_MRW_NS));
                            end
                            CMD_MRR:
                            begin
                                next_state = ST_IDLE_MRR; // [R14]
                                next_timer = TIMER_W'(lpsm_cyc(T_MRR_NS));
                            end
                            CMD_RESET: next_state = ST_RESETTING; // [R13]
                            CMD_PRE:
                            begin
                                next_state = ST_PRECHARGING; // [R15] [R24]
                                next_timer = TIMER_W'(lpsm_cyc(T_RP_NS));
                            end
                            default: next_state = state; // [R19] [R3]
                        endcase
                    end
                    ST_ACTIVE:
                    begin
                        case (cmdS2)
                            CMD_RD: next_state = ST_READING; // [R16]
                            CMD_WR: next_state = ST_WRITING; // [R17]
                            CMD_MRR:
                            begin
                                next_state = ST_ACT_MRR; // [R14]
                                next_timer = TIMER_W'(lpsm_cyc(T_MRR_NS));
                            end
                            CMD_PRE:
                            begin
                                next_state = ST_PRECHARGING; // [R15]
                                next_timer = TIMER_W'(lpsm_cyc(T_RP_NS));
                            end
                            default: next_state = state;
                        endcase
                    end
                    ST_READING, ST_WRITING:
                    begin
                        case (cmdS2)
                            CMD_RD: next_state = ST_READING; // [R16] [R17]
                            CMD_WR: next_state = ST_WRITING; // [R16] [R17]
                            CMD_BST: next_state = ST_ACTIVE; // [R18]
                            default: next_state = state;
                        endcase
                    end
                    ST_POWERON: if (cmdS2 == CMD_RESET) next_state = ST_RESETTING; // [R13]
                    ST_RESETTING:
                    begin
                        if (cmdS2 == CMD_MRR)
                        begin
                            next_state = ST_RST_MRR; // [R14]
                            next_timer = TIMER_W'(lpsm_cyc(T_MRR_NS));
                        end
                    end
                    default: next_state = state;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_POWERON;
            timer <= TIMER_ZERO;
            exitTimer <= TIMER_ZERO;
        end
        else
        begin
            state <= next_state;
            timer <= next_timer;
            exitTimer <= next_exitTimer;
        end
    end

    // Initialization interval restarts on each reset command taken in power-on or idle [R9]
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            initTimer <= TIMER_W'(INIT5_CYC);
        else if (next_state == ST_RESETTING && state != ST_RESETTING && state != ST_RST_PD && state != ST_RST_MRR)
            initTimer <= TIMER_W'(INIT5_CYC);
        else if (initTimer != TIMER_ZERO)
            initTimer <= initTimer - TIMER_ONE;
    end

    // Mode registers and read return
    always_ff @(posedge sys_clk)
    begin
        if (next_state == ST_MRWRITING && state == ST_IDLE)
            modeRegs[maS2] <= mdS2; // [R13]
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link.readData <= 8'h00;
            link.readValid <= 1'b0;
        end
        else
        begin
            link.readValid <= 1'b0;
            if ((next_state == ST_IDLE_MRR || next_state == ST_ACT_MRR || next_state == ST_RST_MRR)
                && next_state != state)
            begin
                link.readData <= modeRegs[maS2]; // [R14]
                link.readValid <= 1'b1;
            end
        end
    end

    // Flags a command the tables do not list [R3]
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            illegal <= 1'b0;
        else
            illegal <= edgeN && ckePrev && ckeS2 && cmdOk && cmdS2 != CMD_NOP && next_state == state
                && !(state == ST_READING && cmdS2 == CMD_RD) && !(state == ST_WRITING && cmdS2 == CMD_WR); // [R3]
    end
endmodule : lpsm_device

// File: design/lpsm_controller.sv
// Controller end: drives link clock, CKE and commands with exit waits
`timescale 1ns/1ps
module lpsm_controller
    import lpsm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    lpsm_link_if.ctrl link,
    input wire logic reqValid,
    input lpsm_cmd_t reqCmd,
    input wire logic reqAll,
    input wire logic [7:0] reqAddr,
    input wire logic [7:0] reqData,
    input wire logic reqCke,
    output logic reqReady,
    output logic [7:0] rspData,
    output logic rspValid
);
    logic [3:0] divCnt;
    logic [7:0] hold;
    logic ckePrevOut;
    logic fallEdge;

    // Link clock from divider; commands change on its falling edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divCnt <= 4'h0;
            link.linkClk <= 1'b0;
        end
        else if (divCnt == LINK_DIV - 4'h1)
        begin
            divCnt <= 4'h0;
            link.linkClk <= ~link.linkClk;
        end
        else
            divCnt <= divCnt + 4'h1;
    end
    assign fallEdge = link.linkClk && divCnt == LINK_DIV - 4'h1;
    assign reqReady = fallEdge && hold == 8'h00;

    // Issue or NOP; hold NOPs after exits and busy commands [R7] [R8] [R21] [R23]
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link.cke <= 1'b1;
            link.csN <= 1'b1;
            link.cmd <= CMD_NOP;
            link.allBanks <= 1'b0;
            link.autoPre <= 1'b0;
            link.modeAddr <= 8'h00;
            link.modeData <= 8'h00;
            hold <= 8'h00;
            ckePrevOut <= 1'b1;
        end
        else if (fallEdge)
        begin
            ckePrevOut <= link.cke;
            link.csN <= 1'b1;
            link.cmd <= CMD_NOP;
            if (hold != 8'h00)
                hold <= hold - 8'h01;
            else
            begin
                link.cke <= reqCke;
                if (!ckePrevOut && reqCke || link.cke && !reqCke)
                    hold <= HOLD_NOP_CYC; // [R7] [R8] [R10]
                if (reqValid && reqCmd != CMD_NOP && !(!link.cke && reqCke))
                begin
                    link.csN <= 1'b0;
                    link.cmd <= reqCmd; // [R3]
                    link.allBanks <= reqAll;
                    link.modeAddr <= reqAddr;
                    link.modeData <= reqData;
                    if (reqCmd != CMD_RD && reqCmd != CMD_WR && reqCmd != CMD_BST)
                        hold <= HOLD_NOP_CYC; // [R21] [R23]
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rspData <= 8'h00;
            rspValid <= 1'b0;
        end
        else
        begin
            rspValid <= link.readValid;
            if (link.readValid)
                rspData <= link.readData;
        end
    end
endmodule : lpsm_controller

// File: test/lpsm_link_properties.sv
// Concurrent checks on the command link between controller and device
`timescale 1ns/1ps
module lpsm_link_properties
    import lpsm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic linkClk,
    input wire logic cke,
    input wire logic csN,
    input lpsm_cmd_t cmd,
    input wire logic readValid
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_linkHigh;
        $rose(linkClk) |=> linkClk [*3] ##1 !linkClk;
    endproperty
    a_linkHigh: assert property (p_linkHigh) else $error("link clock high phase wrong");

    property p_cmdLinkLow;
        $changed(cmd) |-> !linkClk;
    endproperty
    a_cmdLinkLow: assert property (p_cmdLinkLow) else $error("command changed near link rise");

    property p_ckeLinkLow;
        $changed(cke) |-> !linkClk;
    endproperty
    a_ckeLinkLow: assert property (p_ckeLinkLow) else $error("clock enable changed near link rise");

    property p_ckeHold;
        $changed(cke) |=> $stable(cke) [*8];
    endproperty
    a_ckeHold: assert property (p_ckeHold) else $error("clock enable toggled too soon");

    property p_exitNop;
        $rose(cke) |-> csN && cmd == CMD_NOP;
    endproperty
    a_exitNop: assert property (p_exitNop) else $error("power exit without deselect");

    property p_entryCmd;
        $fell(cke) |-> (csN && cmd == CMD_NOP) || (!csN && cmd inside {CMD_NOP, CMD_SREF, CMD_DPD});
    endproperty
    a_entryCmd: assert property (p_entryCmd) else $error("unlisted power entry command");

    property p_mrrAnswer;
        $rose(linkClk) && cke && !csN && cmd == CMD_MRR |-> ##[1:12] readValid;
    endproperty
    a_mrrAnswer: assert property (p_mrrAnswer) else $error("mode read gave no data");

    property p_readPulse;
        readValid |=> !readValid;
    endproperty
    a_readPulse: assert property (p_readPulse) else $error("read valid longer than one cycle");

    property p_nopAfterRefresh;
        $changed(cmd) && cmd == CMD_REFAB |-> ##9 (csN || cmd == CMD_NOP);
    endproperty
    a_nopAfterRefresh: assert property (p_nopAfterRefresh) else $error("command during refresh");

    c_ckeLow: cover property ($fell(cke));
    c_modeRead: cover property (readValid);
    c_activate: cover property ($rose(linkClk) && !csN && cmd == CMD_ACT);
endmodule : lpsm_link_properties

// File: test/tb_sdram_power_bank_state_fsm.sv
// Testbench: controller and device joined over the command link
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module tb_sdram_power_bank_state_fsm
    import lpsm_pkg::*;
();
    localparam int INIT5 = 20;
    localparam int LIMIT = 30000;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reqValid = 1'b0;
    lpsm_cmd_t reqCmd = CMD_NOP;
    logic reqAll = 1'b0;
    logic [7:0] reqAddr = 8'h00;
    logic [7:0] reqData = 8'h00;
    logic reqCke = 1'b1;
    logic reqReady;
    logic [7:0] rspData;
    logic rspValid;
    lpsm_state_t devState;
    logic illegal;
    logic exitWait;
    logic illegalSeen = 1'b0;
    logic [7:0] lastRsp = 8'h00;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;

    lpsm_link_if i_lpsm_link_if ();
    lpsm_controller i_lpsm_controller (.sys_clk(sys_clk), .rst_n(rst_n), .link(i_lpsm_link_if.ctrl),
        .reqValid(reqValid), .reqCmd(reqCmd), .reqAll(reqAll), .reqAddr(reqAddr), .reqData(reqData),
        .reqCke(reqCke), .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid));
    lpsm_device #(.INIT5_CYC(INIT5)) i_lpsm_device (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(i_lpsm_link_if.dev), .state(devState), .illegal(illegal), .exitWait(exitWait));
    lpsm_link_properties i_lpsm_link_properties (.sys_clk(sys_clk), .rst_n(rst_n),
        .linkClk(i_lpsm_link_if.linkClk), .cke(i_lpsm_link_if.cke), .csN(i_lpsm_link_if.csN),
        .cmd(i_lpsm_link_if.cmd), .readValid(i_lpsm_link_if.readValid));

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    always @(posedge sys_clk)
    begin
        cycles++;
        if (illegal === 1'b1)
            illegalSeen = 1'b1;
        if (rspValid === 1'b1)
            lastRsp = rspData;
        if (cycles == LIMIT)
        begin
            err_total++;
            close_out();
        end
    end

    // Hold the request until the controller takes it
    task automatic issue(input lpsm_cmd_t cmd, input logic [7:0] addr, input logic [7:0] data, input logic ck);
        int n;
        n = 0;
        @(negedge sys_clk);
        reqCmd = cmd;
        reqAddr = addr;
        reqData = data;
        reqCke = ck;
        reqValid = 1'b1;
        while (reqReady !== 1'b1 && n < 600)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        reqValid = 1'b0;
    endtask : issue

    task automatic expect_state(input lpsm_state_t exp);
        int n;
        n = 0;
        while (devState !== exp && n < 400)
        begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(devState, exp)
    endtask : expect_state

    task automatic t_reset_path();
        expect_state(ST_POWERON);
        issue(CMD_RESET, 8'h00, 8'h00, 1'b1);
        expect_state(ST_RESETTING);
        issue(CMD_NOP, 8'h00, 8'h00, 1'b0);
        expect_state(ST_RST_PD);
        repeat (40) @(negedge sys_clk);
        `CHK(devState, ST_RST_PD)
        issue(CMD_NOP, 8'h00, 8'h00, 1'b1);
        expect_state(ST_IDLE);
    endtask : t_reset_path

    task automatic t_mode();
        issue(CMD_MRW, 8'h05, 8'hA5, 1'b1);
        expect_state(ST_MRWRITING);
        expect_state(ST_IDLE);
        issue(CMD_MRR, 8'h05, 8'h00, 1'b1);
        expect_state(ST_IDLE_MRR);
        expect_state(ST_IDLE);
        repeat (4) @(negedge sys_clk);
        `CHK(lastRsp, 8'hA5)
    endtask : t_mode

    task automatic t_refresh();
        lpsm_cmd_t cmds [2] = '{CMD_REFPB, CMD_REFAB};
        lpsm_state_t sts [2] = '{ST_REFPB, ST_REFAB};
        for (int i = 0; i < 2; i++)
        begin
            issue(cmds[i], 8'h00, 8'h00, 1'b1);
            expect_state(sts[i]);
            expect_state(ST_IDLE);
        end
    endtask : t_refresh

    // Burst terminate has no meaning while idle
    task automatic t_illegal();
        illegalSeen = 1'b0;
        issue(CMD_BST, 8'h00, 8'h00, 1'b1);
        repeat (20) @(negedge sys_clk);
        `CHK(illegalSeen, 1'b1)
        `CHK(devState, ST_IDLE)
    endtask : t_illegal

    task automatic t_bank();
        issue(CMD_ACT, 8'h00, 8'h00, 1'b1);
        expect_state(ST_ACTIVATING);
        expect_state(ST_ACTIVE);
        issue(CMD_RD, 8'h00, 8'h00, 1'b1);
        expect_state(ST_READING);
        issue(CMD_WR, 8'h00, 8'h00, 1'b1);
        expect_state(ST_WRITING);
        issue(CMD_RD, 8'h00, 8'h00, 1'b1);
        expect_state(ST_READING);
        illegalSeen = 1'b0;
        issue(CMD_RD, 8'h00, 8'h00, 1'b1);
        repeat (20) @(negedge sys_clk);
        `CHK(illegalSeen, 1'b0)
        `CHK(devState, ST_READING)
        issue(CMD_BST, 8'h00, 8'h00, 1'b1);
        expect_state(ST_ACTIVE);
        issue(CMD_WR, 8'h00, 8'h00, 1'b1);
        expect_state(ST_WRITING);
        issue(CMD_BST, 8'h00, 8'h00, 1'b1);
        expect_state(ST_ACTIVE);
        issue(CMD_MRR, 8'h05, 8'h00, 1'b1);
        expect_state(ST_ACT_MRR);
        expect_state(ST_ACTIVE);
        issue(CMD_NOP, 8'h00, 8'h00, 1'b0);
        expect_state(ST_ACT_PD);
        issue(CMD_NOP, 8'h00, 8'h00, 1'b1);
        expect_state(ST_ACTIVE);
        reqAll = 1'b1;
        issue(CMD_PRE, 8'h00, 8'h00, 1'b1);
        expect_state(ST_PRECHARGING);
        expect_state(ST_IDLE);
        reqAll = 1'b0;
        issue(CMD_PRE, 8'h00, 8'h00, 1'b1);
        expect_state(ST_PRECHARGING);
        expect_state(ST_IDLE);
    endtask : t_bank

    task automatic t_power();
        lpsm_cmd_t ent [3] = '{CMD_NOP, CMD_SREF, CMD_DPD};
        lpsm_state_t low [3] = '{ST_IDLE_PD, ST_SELFREF, ST_DEEP_PD};
        lpsm_state_t back [3] = '{ST_IDLE, ST_IDLE, ST_POWERON};
        for (int i = 0; i < 3; i++)
        begin
            issue(ent[i], 8'h00, 8'h00, 1'b0);
            expect_state(low[i]);
            repeat (24) @(negedge sys_clk);
            `CHK(devState, low[i])
            issue(CMD_NOP, 8'h00, 8'h00, 1'b1);
            expect_state(back[i]);
            `CHK(exitWait, (i < 2) ? 1'b1 : 1'b0)
        end
    endtask : t_power

    initial
    begin
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset_path();
        t_mode();
        t_refresh();
        t_illegal();
        t_bank();
        t_power();
        close_out();
    end
endmodule : tb_sdram_power_bank_state_fsm
